/* File: inc/fcs_defines.vh */
// Register offsets, field positions, reset values and timing counts of the clock source control.
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// Register offsets on the byte-wide register port.
`define FCS_ADDR_W            2
`define FCS_OFF_SRC_CTRL      2'h0
`define FCS_OFF_OSC_DIV_CTRL  2'h1
`define FCS_OFF_REF_TRIM      2'h2
`define FCS_OFF_STATUS        2'h3

// Fields of clock_source_control.
`define FCS_SRC_SEL_HI        7
`define FCS_SRC_SEL_LO        6
`define FCS_REF_DIV_HI        5
`define FCS_REF_DIV_LO        3
`define FCS_INT_REF_PICK      2
`define FCS_INT_REF_OUT_EN    1
`define FCS_INT_REF_STOP_KEEP 0

// Fields of oscillator_divider_control.
`define FCS_BUS_DIV_HI        7
`define FCS_BUS_DIV_LO        6
`define FCS_RANGE_HIGH        5
`define FCS_HIGH_GAIN         4
`define FCS_LOOP_PWR_DOWN     3
`define FCS_EXT_REF_PICK      2
`define FCS_EXT_REF_OUT_EN    1
`define FCS_EXT_REF_STOP_KEEP 0

// Fields of the status register.
`define FCS_STAT_SRC_HI       3
`define FCS_STAT_SRC_LO       2
`define FCS_STAT_FINE         0

// Source select codes.
`define FCS_SRC_LOOP          2'h0
`define FCS_SRC_INT           2'h1
`define FCS_SRC_EXT           2'h2
`define FCS_SRC_RSVD          2'h3

// Reset values.
`define FCS_RST_SRC_CTRL      8'h04
`define FCS_RST_OSC_DIV_CTRL  8'h40
`define FCS_RST_REF_TRIM      8'h80
`define FCS_RST_FINE          1'h0

// Full cycles of the new clock seen before a source switch takes effect.
`define FCS_SWITCH_EDGES      3'h4

`endif

/* File: src/fcs_edge_sync.v */
// Two-stage synchroniser for an incoming clock pin with a rising edge pulse.
`timescale 1ns/1ps
`default_nettype none

module fcs_edge_sync (
    // Clock and reset.
    input  wire clock_in,
    input  wire reset_n_in,
    // Asynchronous pin and synchronised results.
    input  wire pin_in,
    output reg  level_out,
    output reg  rise_out
);

    reg meta_q;
    reg last_q;

    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q    <= 1'b0;
            level_out <= 1'b0;
            last_q    <= 1'b0;
            rise_out  <= 1'b0;
        end else begin
            meta_q    <= pin_in;
            level_out <= meta_q;
            last_q    <= level_out;
            rise_out  <= level_out & ~last_q;
        end
    end

endmodule // fcs_edge_sync

`default_nettype wire

/* File: src/fcs_clock_config.v */
// Clock source selection, reference and bus dividers and oscillator controls of the clock generator.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module fcs_clock_config (
    // Clock and reset.
    input  wire                   clock_in,
    input  wire                   reset_n_in,
    // Register port.
    input  wire [`FCS_ADDR_W-1:0] reg_addr_in,
    input  wire [7:0]             reg_wdata_in,
    input  wire                   reg_write_in,
    input  wire                   reg_read_in,
    output reg  [7:0]             reg_rdata_out,
    // Clock pins to be selected and divided.
    input  wire                   loop_clk_in,
    input  wire                   int_ref_clk_in,
    input  wire                   ext_ref_clk_in,
    // Chip state from same-clock logic.
    input  wire                   stop_mode_in,
    input  wire                   background_debug_active_in,
    // Clock results.
    output reg                    bus_tick_out,
    output reg                    ref_div_tick_out,
    output reg  [1:0]             active_source_out,
    output reg                    internal_ref_clock_out,
    output reg                    external_ref_clock_out,
    // Analogue controls.
    output reg                    loop_enable_out,
    output reg                    int_ref_run_out,
    output reg                    ext_ref_run_out,
    output reg                    osc_range_high_out,
    output reg                    osc_high_gain_out,
    output reg                    osc_crystal_request_out,
    output reg  [8:0]             int_ref_trim_out
);

    // Registers seen by software.
    reg  [7:0] src_ctrl_q;
    reg  [7:0] osc_div_ctrl_q;
    reg  [7:0] ref_trim_q;
    reg        fine_period_adjust_q;

    // Source switching and dividers.
    reg  [1:0] active_src_q;
    reg  [1:0] pend_src_q;
    reg  [2:0] switch_cnt_q;
    reg  [2:0] bus_cnt_q;
    reg  [6:0] ref_cnt_q;

    // Stop entry bookkeeping.
    reg        stop_q;
    reg        was_int_mode_q;
    reg        was_ext_mode_q;

    // Synchronised clock pins: index 0 loop, 1 internal, 2 external.
    wire [2:0] clk_pins;
    wire [2:0] clk_level;
    wire [2:0] clk_rise;

    assign clk_pins = {ext_ref_clk_in, int_ref_clk_in, loop_clk_in};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            fcs_edge_sync u_sync (
                .clock_in   (clock_in),
                .reset_n_in (reset_n_in),
                .pin_in     (clk_pins[g]),
                .level_out  (clk_level[g]),
                .rise_out   (clk_rise[g])
            );
        end
    endgenerate

    // Field views.
    wire [1:0] source_select           = src_ctrl_q[`FCS_SRC_SEL_HI:`FCS_SRC_SEL_LO];
    wire [2:0] reference_divider       = src_ctrl_q[`FCS_REF_DIV_HI:`FCS_REF_DIV_LO];
    wire       internal_ref_pick       = src_ctrl_q[`FCS_INT_REF_PICK];
    wire       internal_ref_out_enable = src_ctrl_q[`FCS_INT_REF_OUT_EN];
    wire       internal_ref_stop_keep  = src_ctrl_q[`FCS_INT_REF_STOP_KEEP];
    wire [1:0] bus_divider             = osc_div_ctrl_q[`FCS_BUS_DIV_HI:`FCS_BUS_DIV_LO];
    wire       loop_power_down         = osc_div_ctrl_q[`FCS_LOOP_PWR_DOWN];
    wire       external_ref_out_enable = osc_div_ctrl_q[`FCS_EXT_REF_OUT_EN];
    wire       external_ref_stop_keep  = osc_div_ctrl_q[`FCS_EXT_REF_STOP_KEEP];

    // Reserved code falls back to the loop output.
    wire [1:0] src_req = (source_select == `FCS_SRC_RSVD) ? `FCS_SRC_LOOP : source_select;

    reg  new_rise;
    reg  act_rise;

    always @* begin
        case (pend_src_q)
            `FCS_SRC_INT: new_rise = clk_rise[1];
            `FCS_SRC_EXT: new_rise = clk_rise[2];
            default:      new_rise = clk_rise[0];
        endcase
        case (active_src_q)
            `FCS_SRC_INT: act_rise = clk_rise[1];
            `FCS_SRC_EXT: act_rise = clk_rise[2];
            default:      act_rise = clk_rise[0];
        endcase
    end

    wire ref_rise = internal_ref_pick ? clk_rise[1] : clk_rise[2];

    // Divider limits: 2^n - 1 source edges between output ticks.
    wire [7:0] ref_lim = (8'h01 << reference_divider) - 8'h01;
    wire [3:0] bus_lim = (4'h1 << bus_divider) - 4'h1;

    wire bypass_mode  = (active_src_q != `FCS_SRC_LOOP);
    wire int_mode_now = (active_src_q == `FCS_SRC_INT) |
                        ((active_src_q == `FCS_SRC_LOOP) & internal_ref_pick);
    wire ext_mode_now = (active_src_q == `FCS_SRC_EXT) |
                        ((active_src_q == `FCS_SRC_LOOP) & ~internal_ref_pick);

    // Running conditions of the two references, in and out of stop.
    wire int_ref_on = stop_mode_in ?
                      (internal_ref_stop_keep & (internal_ref_out_enable | was_int_mode_q)) :
                      (internal_ref_out_enable | int_mode_now);
    wire ext_ref_on = stop_mode_in ?
                      (external_ref_stop_keep & (external_ref_out_enable | was_ext_mode_q)) :
                      (external_ref_out_enable | ext_mode_now);

    // Register writes and read-back.
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            src_ctrl_q           <= `FCS_RST_SRC_CTRL;
            osc_div_ctrl_q       <= `FCS_RST_OSC_DIV_CTRL;
            ref_trim_q           <= `FCS_RST_REF_TRIM;
            fine_period_adjust_q <= `FCS_RST_FINE;
            reg_rdata_out        <= 8'h00;
        end else begin
            if (reg_write_in) begin
                case (reg_addr_in)
                    `FCS_OFF_SRC_CTRL:     src_ctrl_q     <= reg_wdata_in;
                    `FCS_OFF_OSC_DIV_CTRL: osc_div_ctrl_q <= reg_wdata_in;
                    `FCS_OFF_REF_TRIM:     ref_trim_q     <= reg_wdata_in;
                    `FCS_OFF_STATUS:       fine_period_adjust_q <= reg_wdata_in[`FCS_STAT_FINE];
                    default: ;
                endcase
            end
            reg_rdata_out <= 8'h00;
            if (reg_read_in) begin
                case (reg_addr_in)
                    `FCS_OFF_SRC_CTRL:     reg_rdata_out <= src_ctrl_q;
                    `FCS_OFF_OSC_DIV_CTRL: reg_rdata_out <= osc_div_ctrl_q;
                    `FCS_OFF_REF_TRIM:     reg_rdata_out <= ref_trim_q;
                    `FCS_OFF_STATUS:       reg_rdata_out <= {4'h0, active_src_q, 1'b0,
                                                             fine_period_adjust_q};
                    default:               reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // Source switch waits for full cycles of the new clock; a silent clock never wins.
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_src_q <= `FCS_SRC_LOOP;
            pend_src_q   <= `FCS_SRC_LOOP;
            switch_cnt_q <= 3'h0;
        end else if (src_req != pend_src_q) begin
            pend_src_q   <= src_req;
            switch_cnt_q <= 3'h0;
        end else if (pend_src_q != active_src_q) begin
            if (new_rise) begin
                if (switch_cnt_q == (`FCS_SWITCH_EDGES - 3'h1)) begin
                    active_src_q <= pend_src_q;
                    switch_cnt_q <= 3'h0;
                end else begin
                    switch_cnt_q <= switch_cnt_q + 3'h1;
                end
            end
        end else begin
            switch_cnt_q <= 3'h0;
        end
    end

    // Bus and reference dividers; a new divide takes effect at once.
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_cnt_q        <= 3'h0;
            bus_tick_out     <= 1'b0;
            ref_cnt_q        <= 7'h00;
            ref_div_tick_out <= 1'b0;
        end else begin
            bus_tick_out     <= 1'b0;
            ref_div_tick_out <= 1'b0;
            if (act_rise & ~stop_mode_in) begin
                if ({1'b0, bus_cnt_q} >= bus_lim) begin
                    bus_cnt_q    <= 3'h0;
                    bus_tick_out <= 1'b1;
                end else begin
                    bus_cnt_q <= bus_cnt_q + 3'h1;
                end
            end
            if (ref_rise) begin
                if ({1'b0, ref_cnt_q} >= ref_lim) begin
                    ref_cnt_q        <= 7'h00;
                    ref_div_tick_out <= 1'b1;
                end else begin
                    ref_cnt_q <= ref_cnt_q + 7'h01;
                end
            end
        end
    end

    // Mode captured on stop entry decides which reference may keep running.
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stop_q         <= 1'b0;
            was_int_mode_q <= 1'b0;
            was_ext_mode_q <= 1'b0;
        end else begin
            stop_q <= stop_mode_in;
            if (stop_mode_in & ~stop_q) begin
                was_int_mode_q <= int_mode_now;
                was_ext_mode_q <= ext_mode_now;
            end
        end
    end

    // Registered controls and gated clock outputs.
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_source_out       <= `FCS_SRC_LOOP;
            internal_ref_clock_out  <= 1'b0;
            external_ref_clock_out  <= 1'b0;
            loop_enable_out         <= 1'b1;
            int_ref_run_out         <= 1'b1;
            ext_ref_run_out         <= 1'b0;
            osc_range_high_out      <= 1'b0;
            osc_high_gain_out       <= 1'b0;
            osc_crystal_request_out <= 1'b0;
            int_ref_trim_out        <= {`FCS_RST_REF_TRIM, `FCS_RST_FINE};
        end else begin
            active_source_out       <= active_src_q;
            internal_ref_clock_out  <= clk_level[1] & internal_ref_out_enable & int_ref_on;
            external_ref_clock_out  <= clk_level[2] & external_ref_out_enable & ext_ref_on;
            loop_enable_out         <= ~stop_mode_in &
                                       ~(loop_power_down & bypass_mode &
                                         ~background_debug_active_in);
            int_ref_run_out         <= int_ref_on;
            ext_ref_run_out         <= ext_ref_on;
            osc_range_high_out      <= osc_div_ctrl_q[`FCS_RANGE_HIGH];
            osc_high_gain_out       <= osc_div_ctrl_q[`FCS_HIGH_GAIN];
            osc_crystal_request_out <= osc_div_ctrl_q[`FCS_EXT_REF_PICK];
            int_ref_trim_out        <= {ref_trim_q, fine_period_adjust_q};
        end
    end

endmodule // fcs_clock_config

`default_nettype wire

/* File: test/fcs_clock_config_checker.sv */
// Concurrent assertions on the ports of the clock source configuration block.
`timescale 1ns/1ps
`default_nettype none

module fcs_clock_config_checker (
    // Clock and reset.
    input wire logic       clock_in,
    input wire logic       reset_n_in,
    // Register port.
    input wire logic [1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_write_in,
    input wire logic       reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // Chip state and results.
    input wire logic       stop_mode_in,
    input wire logic       bus_tick_out,
    input wire logic [1:0] active_source_out,
    input wire logic       internal_ref_clock_out,
    input wire logic       loop_enable_out,
    input wire logic       int_ref_run_out,
    input wire logic       osc_range_high_out,
    input wire logic [8:0] int_ref_trim_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);
    // A control write followed at once by a read of the same register.
    sequence ctrl_write_s;
        reg_write_in && reg_addr_in != 2'h3;
    endsequence
    sequence same_read_s;
        reg_read_in && reg_addr_in == $past(reg_addr_in);
    endsequence
    read_back_a: assert property (ctrl_write_s ##1 same_read_s |=>
        reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("read data differs from the byte just written");
    rdata_idle_a: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    osc_copy_a: assert property (reg_write_in && reg_addr_in == 2'h1 |-> ##2
        osc_range_high_out == $past(reg_wdata_in[5], 2))
        else $error("range output does not follow its bit");
    trim_copy_a: assert property (reg_write_in && reg_addr_in == 2'h2 |-> ##2
        int_ref_trim_out[8:1] == $past(reg_wdata_in, 2))
        else $error("trim output does not follow the trim byte");
    src_legal_a: assert property (active_source_out != 2'h3)
        else $error("reserved source code became active");
    stop_no_tick_a: assert property (stop_mode_in [*2] |-> !bus_tick_out)
        else $error("bus tick seen in stop");
    stop_loop_off_a: assert property (stop_mode_in [*2] |-> !loop_enable_out)
        else $error("loop powered in stop");
    tick_pulse_a: assert property (bus_tick_out |=> !bus_tick_out)
        else $error("bus tick longer than one cycle");
    int_out_gate_a: assert property (!int_ref_run_out [*2] |-> !internal_ref_clock_out)
        else $error("internal clock output active while stopped");
endmodule // fcs_clock_config_checker

bind fcs_clock_config fcs_clock_config_checker u_fcs_clock_config_checker (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .stop_mode_in(stop_mode_in), .bus_tick_out(bus_tick_out),
    .active_source_out(active_source_out), .internal_ref_clock_out(internal_ref_clock_out),
    .loop_enable_out(loop_enable_out), .int_ref_run_out(int_ref_run_out),
    .osc_range_high_out(osc_range_high_out), .int_ref_trim_out(int_ref_trim_out)
);

`default_nettype wire

/* File: test/fcs_clock_config_tb.sv */
// Self-checking bench for the clock source configuration block.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module fcs_clock_config_tb;
    logic        clk;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        stop = 1'b0;
    logic        dbg = 1'b0;
    logic        ext_on = 1'b1;
    logic        ep = 1'b0;
    logic        fine = 1'b0;
    logic        pi, pe, bt, rt, ic, ec, le, ir, er, rh, hg, xr;
    logic [1:0]  addr = 2'h0;
    logic [1:0]  src, src_m, c;
    logic [1:0]  cs [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    logic [3:0]  pc = 4'h0;
    logic [7:0]  wd = 8'h00;
    logic [7:0]  rdat;
    logic [7:0]  m [3];
    logic [8:0]  tr;
    logic [31:0] lf = 32'h4c6a;
    int          num_errors = 0;
    int          checks = 0;
    int          nb, nr, ni, ne;

    fcs_clock_config u_fcs_clock_config (
        .clock_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdat),
        .loop_clk_in(pc[1]), .int_ref_clk_in(pc[2]), .ext_ref_clk_in(ep),
        .stop_mode_in(stop), .background_debug_active_in(dbg),
        .bus_tick_out(bt), .ref_div_tick_out(rt), .active_source_out(src),
        .internal_ref_clock_out(ic), .external_ref_clock_out(ec),
        .loop_enable_out(le), .int_ref_run_out(ir), .ext_ref_run_out(er),
        .osc_range_high_out(rh), .osc_high_gain_out(hg),
        .osc_crystal_request_out(xr), .int_ref_trim_out(tr)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Loop pin every 4 cycles, internal every 8, external every 16 unless held still.
    always @(posedge clk) begin
        pc <= pc + 4'h1;
        if (ext_on)
            ep <= pc[3];
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_cnt(input string n, input int e, input int g);
        checks++;
        if (g < e - 1 || g > e + 1) begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == 2'h3)
            fine = d[0];
        else
            m[a] = d;
    endtask

    // Called on a clock edge; the read data stand in the following cycle.
    task automatic rd_cmp(input logic [1:0] a, input logic [7:0] k);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("reg_read", {1'b0, k & ((a == 2'h3) ? {4'h0, src_m, 1'b0, fine} : m[a])},
            {1'b0, k & rdat});
    endtask

    task automatic complete_run;
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        complete_run();
    end

    initial begin
        m[0] = `FCS_RST_SRC_CTRL;
        m[1] = `FCS_RST_OSC_DIV_CTRL;
        m[2] = `FCS_RST_REF_TRIM;
        src_m = 2'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            @(posedge clk);
            rd_cmp(a[1:0], 8'hff);
        end
        repeat (24) begin
            lf = lfsr(lf);
            wreg(lf[1:0], lf[15:8]);
            rd_cmp(lf[1:0], (lf[1:0] == 2'h3) ? 8'h01 : 8'hff);
            chk("osc_outs", {6'h0, m[1][5], m[1][4], m[1][2]}, {6'h0, rh, hg, xr});
            chk("trim_out", {m[2], fine}, tr);
        end
        for (int k = 0; k < 4; k++) begin
            c = cs[k];
            wreg(2'h0, {c, 6'h04});
            src_m = (c == 2'h3) ? 2'h0 : c;
            repeat (120) @(posedge clk);
            rd_cmp(2'h3, 8'h0c);
            chk("active_source", {7'h0, src_m}, {7'h0, src});
        end
        ext_on <= 1'b0;
        wreg(2'h0, 8'h84);
        repeat (120) @(posedge clk);
        rd_cmp(2'h3, 8'h0c);
        ext_on <= 1'b1;
        wreg(2'h0, 8'h44);
        wreg(2'h1, 8'h08);
        repeat (120) @(posedge clk);
        #1;
        chk("loop_enable", 9'h000, {8'h0, le});
        @(posedge clk);
        dbg <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("loop_enable", 9'h001, {8'h0, le});
        @(posedge clk);
        dbg <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wreg(2'h0, {2'h1, i[2:0], (i != 3), i[0], 1'b0});
            wreg(2'h1, {i[1:0], 4'h0, ~i[0], 1'b0});
            repeat (8) @(posedge clk);
            {nb, nr, ni, ne} = '0;
            pi = ic;
            pe = ec;
            repeat (512) begin
                @(posedge clk);
                #1;
                nb += bt;
                nr += rt;
                ni += ic & !pi;
                ne += ec & !pe;
                pi = ic;
                pe = ec;
            end
            chk_cnt("bus_ticks", 64 >> i, nb);
            chk_cnt("ref_ticks", (i == 3 ? 32 : 64) >> i, nr);
            chk_cnt("int_clock_out", i[0] ? 64 : 0, ni);
            chk_cnt("ext_clock_out", i[0] ? 0 : 32, ne);
        end
        wreg(2'h0, 8'h00);
        repeat (120) @(posedge clk);
        // Bit 4 of the step picks the loop reference, so both stop-entry modes are seen.
        for (int s = 0; s < 32; s++) begin
            wreg(2'h0, {5'h00, s[4], s[1:0]});
            wreg(2'h1, {6'h10, s[3:2]});
            stop <= 1'b1;
            repeat (6) @(posedge clk);
            #1;
            chk("int_run", {8'h0, s[0] & (s[1] | s[4])}, {8'h0, ir});
            chk("ext_run", {8'h0, s[2] & (s[3] | ~s[4])}, {8'h0, er});
            @(posedge clk);
            stop <= 1'b0;
            repeat (3) @(posedge clk);
        end
        complete_run();
    end
endmodule // fcs_clock_config_tb

`default_nettype wire
